// ---- verilog/mtu_uart.sv ----
// serial port for time code messages: host register port, transmit
// queue, transmitter and receiver
// assumes host strobes are asynchronous to CLK_SYS; the data pins are
// joined outside from D_OUT and D_OE

// plain first-in first-out queue with ready/valid on both sides
module mtu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // honest flags from the fill count
  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  // storage has no reset; only the pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers wrap at depth, so depth need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule : mtu_fifo

// Contract
// - select low: address bit 0 low is command/status, high is data; bit 1 ignored.
// - master reset loads the rate field with 11.
// - host writing 11 into the rate field resets the serial port.
// - port stays idle until a valid rate code is written.
// - rate 00, 01, 10 give 9.6, 31.25, 38.4 kHz for both directions.
// - command bits 6:5 steer transmit interrupt, request-to-send and break.
// - command bit 7 enables interrupt on receive full or overrun.
// - status bit 0 sets on received character, clears on data read.
// - status bit 1 clears on data write, sets when character moves onward.
// - status bit 3 mirrors the active-low clear-to-send pin.
// - clear-to-send inactive forces status bit 1 to zero.
// - status bit 4 flags missing first stop bit, kept with its character.
// - status bit 5 sets when a new character overwrites an unread one.
// - reading the data register clears the overrun bit.
// - status bit 7 shows the pending interrupt request.
// - data address writes the transmit buffer and reads the receive buffer.
module mtu_uart
  import mtu_pkg::*;
#(
  parameter logic [CNT_W-1:0] BIT_CYC_SLOW = CNT_W'(CLK_HZ / RATE_SLOW_HZ),
  parameter logic [CNT_W-1:0] BIT_CYC_MID = CNT_W'(CLK_HZ / RATE_MID_HZ),
  parameter logic [CNT_W-1:0] BIT_CYC_FAST = CNT_W'(CLK_HZ / RATE_FAST_HZ)
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic SERIAL_PORT_SELECT_N,
  input wire logic A0,
  input wire logic HOST_RD_N,
  input wire logic HOST_WR_N,
  input wire logic [7:0] D_IN,
  output logic [7:0] D_OUT,
  output logic D_OE,
  output logic IRQ,
  input wire logic RXD,
  output logic TXD,
  input wire logic CTS_N,
  output logic RTS_N
);
  import mtu_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mtu_rx_state_t;

  // bit period for the chosen rate
  function automatic logic [CNT_W-1:0] bit_cycles(input logic [1:0] rate);
    case (rate)
      RATE_SLOW: bit_cycles = BIT_CYC_SLOW;
      RATE_MID: bit_cycles = BIT_CYC_MID;
      default: bit_cycles = BIT_CYC_FAST;
    endcase
  endfunction : bit_cycles

  mtu_host_t host_s1_q;
  mtu_host_t host_s2_q;
  logic [1:0] strobe_prev_q;
  logic [1:0] line_s1_q;
  logic [1:0] line_s2_q;
  logic [7:0] cmd_q;
  logic [7:0] d_out_q;
  logic d_oe_q;
  logic irq_q;
  logic txd_q;
  logic rts_n_q;
  logic [7:0] tx_buf_q;
  logic tx_empty_q;
  mtu_rx_char_t rx_buf_q;
  logic rx_full_q;
  logic overrun_q;
  logic tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bit_q;
  logic [CNT_W-1:0] tx_cnt_q;
  mtu_rx_state_t rx_st_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_bit_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic [7:0] f_out_data;
  logic f_in_ready;
  logic f_out_valid;

  // host pins and line pins pass two flip-flops before use
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      host_s1_q <= HOST_IDLE;
      host_s2_q <= HOST_IDLE;
      line_s1_q <= LINE_IDLE;
      line_s2_q <= LINE_IDLE;
      strobe_prev_q <= LINE_IDLE;
    end else begin
      host_s1_q <= {SERIAL_PORT_SELECT_N, A0, HOST_RD_N, HOST_WR_N, D_IN};
      host_s2_q <= host_s1_q;
      line_s1_q <= {RXD, CTS_N};
      line_s2_q <= line_s1_q;
      strobe_prev_q <= {host_s2_q.rd_n, host_s2_q.wr_n};
    end
  end

  // strobe edges; data and address lag by the same two stages
  wire sel = ~host_s2_q.sel_n;
  wire rd_start = sel & ~host_s2_q.rd_n & strobe_prev_q[1];
  wire rd_end = sel & host_s2_q.rd_n & ~strobe_prev_q[1];
  wire wr_end = sel & host_s2_q.wr_n & ~strobe_prev_q[0];
  wire rd_data_end = rd_end & (host_s2_q.a0 == ADDR_DATA);
  wire wr_cmd = wr_end & (host_s2_q.a0 == ADDR_CMD_STAT);
  wire wr_data = wr_end & (host_s2_q.a0 == ADDR_DATA);
  wire rxd_s = line_s2_q[1];
  wire cts_n_s = line_s2_q[0];

  // command fields
  wire [1:0] rate = cmd_q[RATE_LSB+:2];
  wire [1:0] txc = cmd_q[TXC_LSB+:2];
  wire rx_interrupt_enable = cmd_q[RX_IRQ_EN_BIT];
  wire run = (rate != RATE_OFF);
  wire [CNT_W-1:0] period = bit_cycles(rate);
  wire [CNT_W-1:0] half = {1'b0, period[CNT_W-1:1]};

  // status and interrupt request
  wire tx_empty_eff = tx_empty_q & ~cts_n_s;
  wire rx_irq = rx_interrupt_enable & (rx_full_q | overrun_q);
  wire tx_irq = (txc == TXC_RTS_TXI) & tx_empty_eff;
  wire irq_d = run & (rx_irq | tx_irq);
  mtu_status_t status;
  assign status = '{irq: irq_q, unused6: 1'b0, overrun_flag: overrun_q,
                    framing_error_flag: rx_buf_q.ferr, cts_n: cts_n_s,
                    unused2: 1'b0, tx_empty_flag: tx_empty_eff,
                    rx_full_flag: rx_full_q};

  // host port registers; the data pins are driven only during a read
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cmd_q <= CMD_RESET;
      d_out_q <= ZERO_BYTE;
      d_oe_q <= 1'b0;
      tx_buf_q <= ZERO_BYTE;
    end else begin
      if (wr_cmd) begin
        cmd_q <= host_s2_q.d;
      end
      if (wr_data) begin
        tx_buf_q <= host_s2_q.d;
      end
      if (rd_start) begin
        d_out_q <= (host_s2_q.a0 == ADDR_DATA) ? rx_buf_q.data : status;
      end
      d_oe_q <= sel & ~host_s2_q.rd_n;
    end
  end

  // transmit buffer hands its byte to the queue ahead of the shifter
  wire push = ~tx_empty_q & run;
  wire push_done = push & f_in_ready;
  wire tx_start = ~tx_busy_q & f_out_valid & ~cts_n_s & run & (txc != TXC_BREAK);
  wire tx_tick = tx_busy_q & (tx_cnt_q == '0);

  // the queue only drains while the far end is ready, so it can fill
  // and then hold the buffer flag low
  mtu_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .clr(~run),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(tx_buf_q),
    .out_valid(f_out_valid),
    .out_ready(tx_start),
    .out_data(f_out_data)
  );

  // buffer flag: a host write in the same cycle as a hand-over wins
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tx_empty_q <= 1'b1;
    end else if (!run) begin
      tx_empty_q <= 1'b1;
    end else if (wr_data) begin
      tx_empty_q <= 1'b0;
    end else if (push_done) begin
      tx_empty_q <= 1'b1;
    end
  end

  // transmit shifter: start, eight data bits, stop, lsb first
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= '1;
      tx_bit_q <= '0;
      tx_cnt_q <= '0;
    end else if (!run) begin
      tx_busy_q <= 1'b0;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= {1'b1, f_out_data, 1'b0};
      tx_bit_q <= '0;
      tx_cnt_q <= period - 1'b1;
    end else if (tx_tick) begin
      tx_busy_q <= (tx_bit_q != 4'(FRAME_LAST));
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_bit_q <= tx_bit_q + 1'b1;
      tx_cnt_q <= period - 1'b1;
    end else if (tx_busy_q) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end
  end

  // line outputs; break holds the line low and stops new frames
  wire brk = run & (txc == TXC_BREAK);
  wire txd_d = brk ? 1'b0 : (tx_busy_q ? tx_sh_q[0] : 1'b1);
  wire rts_n_d = ~run | (txc == TXC_NO_RTS);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      txd_q <= 1'b1;
      rts_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      txd_q <= txd_d;
      rts_n_q <= rts_n_d;
      irq_q <= irq_d;
    end
  end

  // receiver samples mid-bit; a start that vanishes at mid-bit is noise
  wire rx_tick = (rx_cnt_q == '0);
  wire rx_done = (rx_st_q == RX_STOP) & rx_tick;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= ZERO_BYTE;
      rx_bit_q <= '0;
      rx_cnt_q <= '0;
    end else if (!run) begin
      rx_st_q <= RX_IDLE;
    end else begin
      rx_cnt_q <= rx_tick ? period - 1'b1 : rx_cnt_q - 1'b1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_cnt_q <= half;
          if (!rxd_s) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_st_q <= rxd_s ? RX_IDLE : RX_DATA;
            rx_bit_q <= '0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // receive buffer and flags; a new character beats a same-cycle read
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rx_buf_q <= '0;
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (!run) begin
      rx_buf_q <= '0;
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_buf_q <= '{ferr: ~rxd_s, data: rx_sh_q};
      end
      rx_full_q <= rx_done | (rx_full_q & ~rd_data_end);
      overrun_q <= (rx_done & rx_full_q & ~rd_data_end) | (overrun_q & ~rd_data_end);
    end
  end

  assign D_OUT = d_out_q;
  assign D_OE = d_oe_q;
  assign IRQ = irq_q;
  assign TXD = txd_q;
  assign RTS_N = rts_n_q;
endmodule : mtu_uart

// ---- verilog/mtu_pkg.sv ----
// constants and carrier types for the serial port block
// assumes a 200 MHz system clock and an 8-bit host data bus
package mtu_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int RATE_SLOW_HZ = 9_600;
  localparam int RATE_MID_HZ = 31_250;
  localparam int RATE_FAST_HZ = 38_400;
  localparam int CNT_W = 15;
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FRAME_LAST = 9;
  // register select on address bit 0
  localparam logic ADDR_CMD_STAT = 1'h0;
  localparam logic ADDR_DATA = 1'h1;
  // command register fields
  localparam int RATE_LSB = 0;
  localparam int TXC_LSB = 5;
  localparam int RX_IRQ_EN_BIT = 7;
  localparam logic [7:0] CMD_RESET = 8'h03;
  localparam logic [1:0] RATE_SLOW = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;
  localparam logic [1:0] RATE_OFF = 2'h3;
  localparam logic [1:0] TXC_RTS = 2'h0;
  localparam logic [1:0] TXC_RTS_TXI = 2'h1;
  localparam logic [1:0] TXC_NO_RTS = 2'h2;
  localparam logic [1:0] TXC_BREAK = 2'h3;
  // synchroniser reset values: strobes and select idle high
  localparam logic [11:0] HOST_IDLE = 12'hB00;
  localparam logic [1:0] LINE_IDLE = 2'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // status register, bit 7 down to bit 0
  typedef struct packed {
    logic irq;
    logic unused6;
    logic overrun_flag;
    logic framing_error_flag;
    logic cts_n;
    logic unused2;
    logic tx_empty_flag;
    logic rx_full_flag;
  } mtu_status_t;

  // one received character with its framing result
  typedef struct packed {
    logic ferr;
    logic [WORD_W-1:0] data;
  } mtu_rx_char_t;

  // host pins after synchronisation
  typedef struct packed {
    logic sel_n;
    logic a0;
    logic rd_n;
    logic wr_n;
    logic [WORD_W-1:0] d;
  } mtu_host_t;
endpackage : mtu_pkg

// ---- dv/mtu_chk.sv ----
// pin-level checker for the serial port block, bound to mtu_uart
// assumes bit periods of at least 8 clock cycles
module mtu_chk (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic SERIAL_PORT_SELECT_N,
  input wire logic A0,
  input wire logic HOST_RD_N,
  input wire logic HOST_WR_N,
  input wire logic [7:0] D_IN,
  input wire logic [7:0] D_OUT,
  input wire logic D_OE,
  input wire logic IRQ,
  input wire logic RXD,
  input wire logic TXD,
  input wire logic CTS_N,
  input wire logic RTS_N
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // read start at the pins: read strobe falling while the port is selected
  sequence rd_start;
    $fell(HOST_RD_N) && !SERIAL_PORT_SELECT_N;
  endsequence
  // status snapshot with clear-to-send steady, so the sync lag cannot matter
  sequence stat_rd;
    $rose(D_OE) && !A0 && (CTS_N == $past(CTS_N, 8));
  endsequence
  reset_idle_a: assert property ($rose(NRST) |-> TXD && RTS_N && !IRQ && !D_OE)
    else $error("outputs not idle after reset");
  read_oe_a: assert property (rd_start |-> ##[2:4] D_OE)
    else $error("no read data after strobe");
  no_read_a: assert property ((HOST_RD_N || SERIAL_PORT_SELECT_N) [*5] |-> !D_OE)
    else $error("bus driven without read");
  dout_hold_a: assert property (D_OE && $past(D_OE) |-> $stable(D_OUT))
    else $error("read data moved during read");
  start_bit_a: assert property ($fell(TXD) |-> !TXD [*8])
    else $error("short low bit on serial out");
  stat_irq_a: assert property ($rose(D_OE) && !A0 |->
    (D_OUT[7] == $past(IRQ)) || (D_OUT[7] == $past(IRQ, 2)) || (D_OUT[7] == $past(IRQ, 3)))
    else $error("status irq bit differs from pin");
  stat_cts_a: assert property (stat_rd |-> D_OUT[3] == CTS_N)
    else $error("status cts bit differs from pin");
  cts_empty_a: assert property (stat_rd ##0 CTS_N |-> !D_OUT[1])
    else $error("empty flag shown while not clear");
endmodule : mtu_chk

bind mtu_uart mtu_chk mtu_chk_inst (.CLK_SYS(CLK_SYS), .NRST(NRST), .SERIAL_PORT_SELECT_N(SERIAL_PORT_SELECT_N),
  .A0(A0), .HOST_RD_N(HOST_RD_N), .HOST_WR_N(HOST_WR_N), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE(D_OE),
  .IRQ(IRQ), .RXD(RXD), .TXD(TXD), .CTS_N(CTS_N), .RTS_N(RTS_N));

// ---- dv/mtu_peer.sv ----
// far-side serial device: sends frames on rxd, decodes txd, drives cts_n
// assumes the bench sets bit_cyc to the port's current bit period
module mtu_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 24;
  logic [7:0] got [$];
  logic [7:0] r;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  // stop bit cut after its middle so a bad stop is not seen as a new start
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (i == 9 ? bit_cyc / 2 + 4 : bit_cyc) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge clk);
  endtask : send
  // decode txd mid-bit, lsb first
  initial forever begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      r[i] = txd;
    end
    repeat (bit_cyc) @(posedge clk);
    got.push_back(r);
  end
endmodule : mtu_peer

// ---- dv/mtu_uart_tb_top.sv ----
// self-checking bench for the serial port block
// assumes bit periods shortened to 16, 20 and 24 cycles
module mtu_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mtu_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sel_n = 1'b1;
  logic a0 = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [7:0] d_in = 8'h00;
  logic [7:0] d_out;
  logic d_oe, irq, rxd, txd, cts_n, rts_n;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] pat [3] = '{8'h35, 8'hCA, 8'h81};
  int cyc_tab [3] = '{16, 20, 24};
  mtu_uart #(.BIT_CYC_SLOW(15'd16), .BIT_CYC_MID(15'd20), .BIT_CYC_FAST(15'd24)) mtu_uart_inst (
    .CLK_SYS(clk), .NRST(nrst), .SERIAL_PORT_SELECT_N(sel_n), .A0(a0), .HOST_RD_N(rd_n),
    .HOST_WR_N(wr_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .IRQ(irq), .RXD(rxd),
    .TXD(txd), .CTS_N(cts_n), .RTS_N(rts_n));
  mtu_peer mtu_peer_inst (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // host write: strobe low 4, address and data held 4 more after rise
  task automatic wr(input logic a, input logic [7:0] d);
    sel_n <= 1'b0;
    a0 <= a;
    d_in <= d;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    sel_n <= 1'b1;
    d_in <= ~d;
    repeat (4) @(posedge clk);
  endtask : wr
  task automatic rd(input logic a, output logic [7:0] d);
    sel_n <= 1'b0;
    a0 <= a;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({7'h00, d_oe}, 8'h01, "no drive");
    d = d_out;
    @(posedge clk);
    rd_n <= 1'b1;
    repeat (5) @(posedge clk);
    sel_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rd
  task automatic wait_rx(input int n);
    for (int k = 0; k < 9000 && mtu_peer_inst.got.size() < n; k++) @(posedge clk);
  endtask : wait_rx
  task automatic t_idle;
    logic [7:0] s;
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'h02, "reset status");
    wr(ADDR_DATA, 8'hA5);
    repeat (300) @(posedge clk);
    chk({7'h00, txd}, 8'h01, "sent while idle");
    chk(8'(mtu_peer_inst.got.size()), 8'h00, "frame while idle");
    wr(ADDR_CMD_STAT, CMD_RESET);
    wr(ADDR_CMD_STAT, 8'h02);
    repeat (300) @(posedge clk);
    chk(8'(mtu_peer_inst.got.size()), 8'h00, "stale byte sent");
    $display("test idle done");
  endtask : t_idle
  // every rate code, both directions
  task automatic t_rates;
    logic [7:0] s;
    for (int r = 0; r < 3; r++) begin
      mtu_peer_inst.bit_cyc = cyc_tab[r];
      wr(ADDR_CMD_STAT, {1'b0, TXC_RTS, 3'h0, 2'(r)});
      chk({7'h00, rts_n}, 8'h00, "rts off");
      wr(ADDR_DATA, pat[r]);
      wait_rx(1);
      chk(mtu_peer_inst.got.pop_front(), pat[r], "tx byte");
      mtu_peer_inst.send(~pat[r], 1'b1);
      rd(ADDR_CMD_STAT, s);
      chk(s, 8'h03, "rx not full");
      rd(ADDR_DATA, s);
      chk(s, ~pat[r], "rx byte");
      rd(ADDR_CMD_STAT, s);
      chk(s, 8'h02, "full after read");
    end
    $display("test rates done");
  endtask : t_rates
  task automatic t_err;
    logic [7:0] s;
    wr(ADDR_CMD_STAT, 8'h82);
    mtu_peer_inst.send(8'h11, 1'b0);
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'h93, "framing status");
    chk({7'h00, irq}, 8'h01, "no irq");
    mtu_peer_inst.send(8'h22, 1'b1);
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'hA3, "overrun status");
    rd(ADDR_DATA, s);
    chk(s, 8'h22, "newest byte");
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'h02, "overrun kept");
    chk({7'h00, irq}, 8'h00, "irq stuck");
    $display("test errors done");
  endtask : t_err
  // clear-to-send held off: queue fills, then drains in order
  task automatic t_cts;
    logic [7:0] s;
    mtu_peer_inst.cts_n <= 1'b1;
    wr(ADDR_CMD_STAT, 8'h02);
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'h08, "cts status");
    for (int i = 0; i < 17; i++) wr(ADDR_DATA, 8'h40 + 8'(i));
    chk(8'(mtu_peer_inst.got.size()), 8'h00, "sent while held");
    mtu_peer_inst.cts_n <= 1'b0;
    wait_rx(17);
    for (int i = 0; i < 17; i++) chk(mtu_peer_inst.got.pop_front(), 8'h40 + 8'(i), "queue order");
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'h02, "not empty");
    $display("test cts done");
  endtask : t_cts
  task automatic t_txctl;
    logic [7:0] s;
    wr(ADDR_CMD_STAT, 8'h22);
    chk({7'h00, irq}, 8'h01, "no tx irq");
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'h82, "irq status");
    wr(ADDR_CMD_STAT, 8'h42);
    chk({6'h00, rts_n, irq}, 8'h02, "rts or irq");
    mtu_peer_inst.send(8'h5C, 1'b1);
    wr(ADDR_CMD_STAT, 8'h62);
    repeat (20) @(posedge clk);
    chk({6'h00, rts_n, txd}, 8'h00, "no break");
    wr(ADDR_CMD_STAT, CMD_RESET);
    rd(ADDR_CMD_STAT, s);
    chk(s, 8'h02, "not reset");
    $display("test txctl done");
  endtask : t_txctl
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_idle();
    t_rates();
    t_err();
    t_cts();
    t_txctl();
    tally_and_finish();
  end
endmodule : mtu_uart_tb_top
